// *** common/rdf_pkg.sv ***
package rdf_pkg;
	localparam int ADDR_W = 12;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTL = 8'h40;
	localparam logic [7:0] IDX_LIM = 8'h41;
	localparam logic [7:0] IDX_AEQ = 8'h42;
	localparam logic [7:0] IDX_THR = 8'h43;
	localparam logic [7:0] IDX_RLK = 8'h44;
	localparam logic [7:0] IDX_STS = 8'h45;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_LIM = 8'h86;
	localparam logic [6:0] RST_AEQ = 7'h74;
	localparam logic [7:0] RST_THR = 8'h01;
	localparam logic [15:0] RST_RLK = 16'h0400;
	localparam int CTL_ALWAYS = 7;
	localparam int CTL_TIMING = 1;
	localparam int CTL_EN = 0;
	localparam int AEQ_CLS_LSB = 4;
	localparam int AEQ_ORDER = 3;
	localparam int AEQ_2STEP = 2;
	localparam int AEQ_FIL_EN = 0;
	localparam int LIM_MAX_LSB = 4;
	localparam int STS_ADAPT = 4;
	localparam int STS_SWEEP = 5;
	localparam logic [3:0] SET_MID = 4'h7;
	localparam logic [3:0] SET_LEGAL_MAX = 4'hE;
	localparam logic [3:0] SET_ONE = 4'h1;
	localparam logic [15:0] HALF_MIN = 16'h0001;
	// bit order matches the error-class select field
	typedef struct packed {
		logic clk_bit;
		logic seq;
		logic parity;
	} rdf_err_t;
	typedef struct packed {
		logic [3:0] max;
		logic [3:0] min;
	} rdf_lim_t;
	typedef enum {F_IDLE, F_DYN, F_SWEEP} rdf_fil_st_t;
	typedef enum {E_IDLE, E_ACCUM, E_WAIT, E_CHECK} rdf_err_st_t;
endpackage

// *** rtl/rdf_err_acc.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdf_err_acc
	import rdf_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire rdf_pkg::rdf_err_t link_err,
	input wire logic [2:0] class_sel,
	input wire logic [7:0] threshold,
	input wire logic [15:0] half_period,
	input wire logic eq_active,
	input wire logic two_step,
	input wire logic cand_start,
	input wire logic lock,
	output logic step_up,
	output logic cand_pass,
	output logic cand_fail
);
	rdf_err_st_t state, next_state;
	logic [15:0] tick, next_tick;
	logic [7:0] errcnt, next_errcnt;
	logic next_step_up, next_cand_pass, next_cand_fail;
	logic hit, tick_end;
	logic [7:0] cnt_now;

	assign hit = |(link_err & class_sel);
	assign tick_end = (tick >= half_period - HALF_MIN);
	// count including this cycle, so the window's last error is not lost
	// saturate so a long burst cannot wrap back under the threshold
	assign cnt_now = (hit && errcnt != 8'hFF) ? errcnt + 8'h01 : errcnt;

	always_comb
	begin
		next_state = state;
		next_tick = tick + HALF_MIN;
		next_errcnt = cnt_now;
		next_step_up = 1'b0;
		next_cand_pass = 1'b0;
		next_cand_fail = 1'b0;
		unique case (state)
			E_IDLE:
			begin
				next_tick = '0;
				next_errcnt = '0;
				if (cand_start)
					next_state = E_WAIT;
				else if (eq_active)
					next_state = E_ACCUM;
			end
			E_ACCUM:
			begin
				if (tick_end)
				begin
					next_tick = '0;
					next_errcnt = '0;
					next_step_up = (cnt_now > threshold);
				end
				if (cand_start)
				begin
					next_state = E_WAIT;
					next_tick = '0;
				end
				else if (!eq_active)
					next_state = E_IDLE;
			end
			E_WAIT:
			begin
				next_errcnt = '0;
				if (tick_end)
				begin
					next_tick = '0;
					next_state = E_CHECK;
				end
			end
			E_CHECK:
			begin
				if (two_step && hit)
				begin
					next_cand_fail = 1'b1;
					next_state = E_IDLE;
				end
				else if (tick_end)
				begin
					next_cand_pass = lock;
					next_cand_fail = !lock;
					next_state = E_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state <= E_IDLE;
			tick <= '0;
			errcnt <= '0;
			step_up <= 1'b0;
			cand_pass <= 1'b0;
			cand_fail <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tick <= next_tick;
			errcnt <= next_errcnt;
			step_up <= next_step_up;
			cand_pass <= next_cand_pass;
			cand_fail <= next_cand_fail;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_check_err;
		state == E_CHECK && two_step && hit;
	endsequence

	a_step_cause: assert property (step_up |->
		$past(state == E_ACCUM && tick_end && cnt_now > threshold))
		else $error("step up without excess errors");
	a_step_excess: assert property (state == E_ACCUM && tick_end
		&& cnt_now > threshold |=> step_up)
		else $error("excess errors gave no step up");
	a_two_step_fail: assert property (s_check_err |=>
		cand_fail && state == E_IDLE)
		else $error("two-step error did not fail candidate");
	a_wait_quiet: assert property (state == E_WAIT |=>
		!cand_fail && !cand_pass)
		else $error("verdict during first half");
	a_class_gate: assert property (state == E_ACCUM
		&& class_sel == 3'h0 && !tick_end |=> errcnt == $past(errcnt))
		else $error("error counted with no class enabled");
	a_window_len: assert property (state == E_ACCUM && !cand_start
		&& eq_active && $stable(half_period) |-> tick < half_period
		|| half_period == 16'h0000)
		else $error("accumulation window overrun");
endmodule
`default_nettype wire

// *** rtl/rdf_adapt_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdf_adapt_ctl
	import rdf_pkg::*;
#(
	parameter logic [15:0] RELOCK_RESET = RST_RLK
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rdf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cdr_freq_lock,
	input wire logic eq_adapt_done,
	input wire logic eq_sweep_start,
	input wire logic eq_sweep_next,
	input wire logic eq_candidate_start,
	input wire rdf_pkg::rdf_err_t link_err,
	input wire logic filter_early,
	input wire logic filter_late,
	output logic [3:0] filter_setting,
	output logic filter_adapting,
	output logic eq_step_up,
	output logic eq_candidate_pass,
	output logic eq_candidate_fail
);
	import rdf_pkg::*;

	logic [7:0] ctl, next_ctl;
	rdf_lim_t lim, next_lim;
	logic [6:0] adaptive_equalizer, next_aeq;
	logic [7:0] thr, next_thr;
	logic [15:0] rlk, next_rlk;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [7:0] idx;
	logic mapped, setup, wr_en;
	logic [7:0] sts;

	rdf_fil_st_t state, next_state;
	logic [3:0] next_setting;
	logic next_adapting;
	logic [3:0] eff_min, eff_max;
	logic dyn_go, sweep_go, eq_active;
	logic [15:0] half_period;

	function automatic logic [3:0] clamp(input logic [3:0] v,
		input logic [3:0] lo, input logic [3:0] hi);
		logic [3:0] r;
		r = v;
		if (r > hi)
			r = hi;
		if (r < lo)
			r = lo;
		return r;
	endfunction

	// bus decode
	assign idx = paddr[9:2];
	assign mapped = (paddr[11:10] == 2'b00) && (idx == IDX_CTL
		|| idx == IDX_LIM || idx == IDX_AEQ || idx == IDX_THR
		|| idx == IDX_RLK || idx == IDX_STS);
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;
	assign sts = {2'b00, state == F_SWEEP, filter_adapting,
		filter_setting};

	always_comb
	begin
		next_ctl = ctl;
		next_lim = lim;
		next_aeq = adaptive_equalizer;
		next_thr = thr;
		next_rlk = rlk;
		next_pready = setup;
		next_pslverr = setup && !mapped;
		next_prdata = '0;
		if (setup && !pwrite)
		begin
			unique case (idx)
				IDX_CTL: next_prdata = {24'h000000, ctl};
				IDX_LIM: next_prdata = {24'h000000, lim};
				IDX_AEQ: next_prdata = {25'h0000000, adaptive_equalizer};
				IDX_THR: next_prdata = {24'h000000, thr};
				IDX_RLK: next_prdata = {16'h0000, rlk};
				IDX_STS: next_prdata = {24'h000000, sts};
				default: next_prdata = '0;
			endcase
		end
		// status register ignores writes
		if (wr_en)
		begin
			unique case (idx)
				IDX_CTL: next_ctl = pwdata[7:0];
				IDX_LIM: next_lim = pwdata[7:0];
				// class, order, two-step and filter-enable bits; bit 7 reads zero
				IDX_AEQ: next_aeq = pwdata[6:0];
				IDX_THR: next_thr = pwdata[7:0];
				IDX_RLK: next_rlk = pwdata[15:0];
				default: next_ctl = ctl;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ctl <= RST_CTL;
			lim <= RST_LIM;
			adaptive_equalizer <= RST_AEQ;
			thr <= RST_THR;
			rlk <= RELOCK_RESET;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			ctl <= next_ctl;
			lim <= next_lim;
			adaptive_equalizer <= next_aeq;
			thr <= next_thr;
			rlk <= next_rlk;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// out-of-range codes fold to the legal top
	assign eff_max = clamp(lim.max, 4'h0, SET_LEGAL_MAX);
	assign eff_min = clamp(lim.min, 4'h0, SET_LEGAL_MAX);
	assign dyn_go = ctl[CTL_EN] && (ctl[CTL_ALWAYS]
		|| (ctl[CTL_TIMING] ? eq_adapt_done : cdr_freq_lock));
	assign sweep_go = eq_sweep_start && adaptive_equalizer[AEQ_FIL_EN];
	// checking only with a class enabled
	assign eq_active = !eq_adapt_done
		&& (adaptive_equalizer[6:AEQ_CLS_LSB] != 3'b000);
	// zero period would stall the window, so floor it at one
	assign half_period = (rlk[15:1] == 15'h0000) ? HALF_MIN
		: {1'b0, rlk[15:1]};

	always_comb
	begin
		next_state = state;
		next_setting = filter_setting;
		unique case (state)
			F_IDLE, F_DYN:
			begin
				if (sweep_go)
					next_state = F_SWEEP;
				else if (dyn_go)
					next_state = F_DYN;
				else
					next_state = F_IDLE;
				if (state == F_DYN && dyn_go && !sweep_go)
				begin
					if (filter_early && !filter_late
						&& filter_setting < eff_max)
						next_setting = filter_setting + SET_ONE;
					else if (filter_late && !filter_early
						&& filter_setting > eff_min)
						next_setting = filter_setting - SET_ONE;
				end
				if (sweep_go)
					next_setting = adaptive_equalizer[AEQ_ORDER] ? SET_MID : eff_max;
			end
			F_SWEEP:
			begin
				// walk down, wrap to the top
				if (eq_sweep_next)
					next_setting = (filter_setting <= eff_min) ? eff_max
						: filter_setting - SET_ONE;
				if (eq_adapt_done)
					next_state = dyn_go ? F_DYN : F_IDLE;
			end
		endcase
		next_setting = clamp(next_setting, eff_min, eff_max);
		next_adapting = (next_state != F_IDLE);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state <= F_IDLE;
			filter_setting <= SET_MID;
			filter_adapting <= 1'b0;
		end
		else
		begin
			state <= next_state;
			filter_setting <= next_setting;
			filter_adapting <= next_adapting;
		end
	end

	rdf_err_acc u_err
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.link_err(link_err),
		.class_sel(adaptive_equalizer[6:AEQ_CLS_LSB]),
		.threshold(thr),
		.half_period(half_period),
		.eq_active(eq_active),
		.two_step(adaptive_equalizer[AEQ_2STEP]),
		.cand_start(eq_candidate_start),
		.lock(cdr_freq_lock),
		.step_up(eq_step_up),
		.cand_pass(eq_candidate_pass),
		.cand_fail(eq_candidate_fail)
	);

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_idle_no_sweep;
		state == F_IDLE && !sweep_go;
	endsequence

	sequence s_sweep_step;
		state == F_SWEEP && eq_sweep_next && !eq_adapt_done
			&& filter_setting > eff_min && $stable(lim);
	endsequence

	a_apb_answer: assert property (setup |=> pready && (pslverr
		== !$past(mapped)))
		else $error("apb access phase not answered");
	a_lock_start: assert property (s_idle_no_sweep and
		(ctl[CTL_EN] && !ctl[CTL_ALWAYS] && !ctl[CTL_TIMING]
		&& cdr_freq_lock) |=> state == F_DYN)
		else $error("adaption not started on lock");
	a_eq_wait: assert property (s_idle_no_sweep and
		(!ctl[CTL_ALWAYS] && ctl[CTL_TIMING] && !eq_adapt_done)
		|=> state == F_IDLE)
		else $error("adaption started before equalizer done");
	a_eq_done_start: assert property (s_idle_no_sweep and
		(ctl[CTL_EN] && !ctl[CTL_ALWAYS] && ctl[CTL_TIMING]
		&& eq_adapt_done) |=> state == F_DYN)
		else $error("adaption not started after equalizer done");
	a_always_on: assert property (s_idle_no_sweep and
		(ctl[CTL_EN] && ctl[CTL_ALWAYS]) |=> state == F_DYN)
		else $error("always-on did not start adaption");
	a_dyn_gate: assert property (!ctl[CTL_EN] && state != F_SWEEP
		&& !sweep_go |=> state == F_IDLE)
		else $error("dynamic adaption while disabled");
	a_idle_hold: assert property (state == F_IDLE && !sweep_go
		&& $stable(lim) |=> filter_setting == $past(filter_setting))
		else $error("setting moved while not adapting");
	a_order_start: assert property (sweep_go && state != F_SWEEP
		&& $stable(lim) |=> filter_setting == clamp($past(adaptive_equalizer[AEQ_ORDER])
		? SET_MID : $past(eff_max), $past(eff_min), $past(eff_max)))
		else $error("sweep started at wrong setting");
	a_sweep_step: assert property (s_sweep_step |=>
		filter_setting == $past(filter_setting) - SET_ONE)
		else $error("sweep step not one down");
	a_sweep_wrap: assert property (state == F_SWEEP && eq_sweep_next
		&& !eq_adapt_done && filter_setting <= eff_min
		&& eff_min <= eff_max && $stable(lim)
		|=> filter_setting == $past(eff_max))
		else $error("sweep did not wrap to maximum");
	a_set_clamp: assert property ($stable(lim) && eff_min <= eff_max
		&& $past(eff_min) <= $past(eff_max) |-> filter_setting >= eff_min
		&& filter_setting <= eff_max)
		else $error("setting outside limits");
	a_dyn_up: assert property (state == F_DYN && dyn_go && !sweep_go
		&& filter_early && !filter_late && filter_setting < eff_max
		&& $stable(lim) |=> filter_setting == $past(filter_setting)
		+ SET_ONE)
		else $error("dynamic step up missing");
	a_dyn_down: assert property (state == F_DYN && dyn_go
		&& !sweep_go && filter_late && !filter_early
		&& filter_setting > eff_min && $stable(lim)
		|=> filter_setting == $past(filter_setting) - SET_ONE)
		else $error("dynamic step down missing");
	a_limit_write: assert property (wr_en && idx == IDX_LIM
		|=> lim == $past(pwdata[7:0]))
		else $error("limit write lost");
endmodule
`default_nettype wire

// *** verif/rdf_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdf_link_model
(
	input wire logic core_clk,
	input wire logic [2:0] err_pat,
	input wire logic vote_on,
	output var rdf_pkg::rdf_err_t link_err,
	output logic filter_early,
	output logic filter_late
);
	import rdf_pkg::*;
	int seed = 65434;
	int r;
	// votes never both high, the design would drop them anyway
	always @(posedge core_clk)
	begin
		r = $random(seed);
		link_err <= err_pat;
		filter_early <= vote_on & r[0];
		filter_late <= vote_on & r[1] & ~r[0];
	end
endmodule
`default_nettype wire

// *** verif/rx_delay_filter_adapt_ctl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_delay_filter_adapt_ctl_test;
	import rdf_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, e, early, late, adapting, up, pass, fail;
	logic lock = 1'b0, done = 1'b0, sw_start = 1'b0, sw_next = 1'b0;
	logic cand = 1'b0, vote = 1'b0;
	logic [2:0] pat = 3'h0;
	logic [3:0] fset, f0;
	rdf_err_t link_err;
	int mismatches = 0, comparisons = 0, nup = 0, npass = 0, nfail = 0;
	int n0, n1;
	int mdl [int];
	logic [10:0] act [6] = '{11'h409, 11'h008, 11'h00D, 11'h01C, 11'h01F,
		11'h006};
	logic [3:0] cnd [4] = '{4'hB, 4'hE, 4'h7, 4'h8};
	always #20 core_clk = ~core_clk;
	rdf_adapt_ctl #(.RELOCK_RESET(16'h0010)) dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cdr_freq_lock(lock), .eq_adapt_done(done),
		.eq_sweep_start(sw_start), .eq_sweep_next(sw_next),
		.eq_candidate_start(cand), .link_err(link_err),
		.filter_early(early), .filter_late(late), .filter_setting(fset),
		.filter_adapting(adapting), .eq_step_up(up),
		.eq_candidate_pass(pass), .eq_candidate_fail(fail));
	rdf_link_model lm (.core_clk(core_clk), .err_pat(pat), .vote_on(vote),
		.link_err(link_err), .filter_early(early), .filter_late(late));
	always @(posedge core_clk)
	begin
		nup += (up === 1'b1);
		npass += (pass === 1'b1);
		nfail += (fail === 1'b1);
	end
	task automatic results();
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, x);
		comparisons++;
		if (s !== x)
		begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, s);
		end
	endtask
	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		mismatches += (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] msk(input logic [7:0] i);
		return i == IDX_AEQ ? 32'h7F : i == IDX_RLK ? 32'hFFFF : 32'hFF;
	endfunction
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
		mdl[i] = d & msk(i);
	endtask
	task automatic rd(input logic [7:0] i);
		apb(1'b0, i, 32'h0);
		chk("reg", q, mdl[i]);
		chk("err", {31'h0, e}, 32'h0);
	endtask
	// settle first so a window left over from before cannot fire
	task automatic errwin(input logic [2:0] p, input logic x);
		pat <= 3'h0;
		repeat (20) @(posedge core_clk);
		n0 = nup;
		pat <= p;
		repeat (40) @(posedge core_clk);
		chk("step_up", {31'h0, nup > n0}, {31'h0, x});
		pat <= 3'h0;
	endtask
	initial
	begin
		mdl[IDX_CTL] = RST_CTL;
		mdl[IDX_LIM] = RST_LIM;
		mdl[IDX_AEQ] = RST_AEQ;
		mdl[IDX_THR] = RST_THR;
		mdl[IDX_RLK] = 32'h10;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		foreach (mdl[i]) rd(i[7:0]);
		apb(1'b0, 8'h46, 32'h0);
		chk("unmapped", {31'h0, e}, 32'h1);
		foreach (mdl[i]) wr(i[7:0], 32'hFFFFFF5A);
		foreach (mdl[i]) rd(i[7:0]);
		chk("min_wins", fset, 32'hA);
		apb(1'b0, IDX_STS, 32'h0);
		chk("status", q, 32'h0A);
		wr(IDX_RLK, 32'h10);
		wr(IDX_THR, 32'h1);
		wr(IDX_CTL, 32'h0);
		wr(IDX_LIM, 32'h94);
		repeat (2) @(posedge core_clk);
		chk("clamp", fset, 32'h9);
		for (int k = 0; k < 2; k++)
		begin
			wr(IDX_AEQ, k ? 32'h7D : 32'h75);
			sw_start <= 1'b1;
			@(posedge core_clk);
			sw_start <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("sweep_start", fset, k ? SET_MID : 4'h9);
			sw_next <= 1'b1;
			@(posedge core_clk);
			sw_next <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("sweep_next", fset, k ? 4'h6 : 4'h8);
			done <= 1'b1;
			repeat (3) @(posedge core_clk);
			done <= 1'b0;
		end
		vote <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			wr(IDX_CTL, {24'h0, act[k][10:3]});
			lock <= act[k][2];
			done <= act[k][1];
			repeat (4) @(posedge core_clk);
			f0 = fset;
			chk("adapting", {31'h0, adapting}, {31'h0, act[k][0]});
			repeat (20)
			begin
				@(posedge core_clk);
				chk("range", {31'h0, fset >= 4'h4 && fset <= 4'h9}, 32'h1);
			end
			if (!act[k][0])
				chk("hold", fset, f0);
		end
		vote <= 1'b0;
		done <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_AEQ, c < 3 ? 32'h04 | (32'h10 << c) : 32'h04);
			errwin(c < 3 ? 3'(1 << c) : 3'h7, c < 3);
			if (c < 3)
				errwin(3'h7 ^ 3'(1 << c), 1'b0);
		end
		wr(IDX_AEQ, 32'h74);
		for (int t = 7; t < 9; t++)
		begin
			wr(IDX_THR, t);
			errwin(3'h1, t == 7);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_AEQ, cnd[k][3] ? 32'h74 : 32'h70);
			lock <= cnd[k][1];
			pat <= {2'h0, cnd[k][2]};
			n0 = npass;
			n1 = nfail;
			cand <= 1'b1;
			@(posedge core_clk);
			cand <= 1'b0;
			repeat (24) @(posedge core_clk);
			chk("pass", npass - n0, {31'h0, cnd[k][0]});
			chk("fail", nfail - n1, {31'h0, !cnd[k][0]});
			pat <= 3'h0;
		end
		results();
	end
	initial
	begin
		#(40 * 40000);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
